// [logic/six_channel_pwm_pkg.sv]
// six_channel_pwm_pkg: shared constants for the six-channel modulator
// assumes: compiled before any design file that uses it
`default_nettype none
package six_channel_pwm_pkg;
  localparam int unsigned num_channels = 6;   // channel count
  localparam int unsigned chan_width = 8;     // bits per single channel
  localparam int unsigned pair_count = 3;     // concatenated pairs
  localparam logic [7:0] period_reset = 8'hff; // period reset value
  localparam logic [7:0] duty_reset = 8'hff;   // duty reset value
  localparam logic [7:0] count_reset = 8'h00;  // counter reset value
  localparam logic [2:0] prescale_reset = 3'h0; // prescaler select reset
  localparam logic [7:0] scale_reset = 8'h00;  // scale divider reset (0 means 256)
  localparam int unsigned shutdown_sync_stages = 2; // pin synchroniser depth
endpackage
`default_nettype wire

// [logic/pwm_channel.sv]
// pwm_channel: one 8/16-bit counter with buffered period and duty
// assumes: tick is a one-cycle enable from the clock-select logic
`timescale 1ns/10ps
`default_nettype none
module pwm_channel #(
  parameter int unsigned width = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic centre,
  input wire logic polarity,
  input wire logic [width-1:0] period_buf,
  input wire logic [width-1:0] duty_buf,
  output logic [width-1:0] count,
  output logic wave
);
  logic [width-1:0] period_reg; // active period
  logic [width-1:0] duty_reg;   // active duty
  logic [width-1:0] count_reg;
  logic down_reg;               // centre mode count direction
  logic duty_reg_state;         // raw duty phase (1 = in duty)
  wire period_end;
  wire at_top;
  wire duty_hit;
  wire in_duty;
  wire boundary;

  assign at_top = (count_reg >= period_reg - 1'b1) && !centre
                  || (count_reg >= period_reg) && centre;
  assign period_end = centre ? (down_reg && count_reg <= 1) : at_top;
  assign duty_hit = (count_reg == duty_reg);
  assign boundary = !enable || (tick && (period_end || period_reg == '0));
  // both duty extremes
  // duty 0 inactive, duty >= period fully active when period is nonzero
  assign in_duty = (duty_reg >= period_reg && period_reg != '0) ? 1'b1 :
                   (duty_reg == '0) ? 1'b0 : duty_reg_state;
  assign count = count_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_reg <= '0;
      duty_reg <= '0;
    end else if (boundary) begin
      period_reg <= period_buf;
      duty_reg <= duty_buf;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      down_reg <= 1'b0;
      duty_reg_state <= 1'b1;
    end else if (!enable) begin
      count_reg <= '0;
      down_reg <= 1'b0;
      duty_reg_state <= 1'b1;
    end else if (tick) begin
      if (!centre) begin
        if (at_top) begin
          count_reg <= '0;
          duty_reg_state <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
          if (count_reg + 1'b1 == duty_reg) duty_reg_state <= 1'b0;
        end
      end else begin
        if (!down_reg) begin
          if (at_top) begin
            down_reg <= 1'b1;
            count_reg <= count_reg - 1'b1;
          end else begin
            count_reg <= count_reg + 1'b1;
          end
        end else if (count_reg == '0) begin
          down_reg <= 1'b0;
          count_reg <= count_reg + 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
        // toggle on match gives symmetric pulse
        if (duty_hit) duty_reg_state <= !duty_reg_state;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wave <= 1'b0;
    else wave <= enable ? (in_duty ~^ polarity) : 1'b0;
  end
endmodule
`default_nettype wire

// [logic/six_channel_pwm.sv]
// six_channel_pwm: six 8-bit or three 16-bit modulator channels
// assumes: settings are static ports from a register block on clk
`timescale 1ns/10ps
`default_nettype none
module six_channel_pwm (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] chan_enable,
  input wire logic [5:0] chan_polarity,
  input wire logic [5:0] chan_clock_scaled,
  input wire logic [5:0] chan_centre,
  input wire logic [2:0] prescale_a,
  input wire logic [2:0] prescale_b,
  input wire logic [7:0] scale_a,
  input wire logic [7:0] scale_b,
  input wire logic [2:0] concat_pair,
  input wire logic stop_in_wait,
  input wire logic stop_in_freeze,
  input wire logic wait_mode,
  input wire logic freeze_mode,
  input wire logic shutdown_enable,
  input wire logic shutdown_level,
  input wire logic shutdown_restart,
  input wire logic [47:0] period_set,
  input wire logic [47:0] duty_set,
  input wire logic pin5_in,
  output logic [5:0] pwm_out,
  output logic pin5_oe,
  output logic shutdown_active,
  output logic [47:0] count_state
);
  localparam int unsigned nc = six_channel_pwm_pkg::num_channels;
  localparam int unsigned cw = six_channel_pwm_pkg::chan_width;

  logic [6:0] prescale_reg;       // free prescaler
  logic [7:0] scale_a_cnt_reg;    // scaled clock a divider
  logic [7:0] scale_b_cnt_reg;    // scaled clock b divider
  logic scaled_clock_a_reg;       // divided-by-two output
  logic scaled_clock_b_reg;
  logic [6:0] prescale_next;
  logic [1:0] pin_sync_reg;       // shutdown pin synchroniser
  logic shut_reg;
  wire prescale_run;
  wire [7:0] tap;
  wire clock_a;
  wire clock_b;
  wire scaled_clock_a;
  wire scaled_clock_b;
  wire [5:0] tick;
  wire [5:0] chan_wave;
  wire [5:0] chan_on;
  wire shut_event;

  assign prescale_run = !(stop_in_wait && wait_mode) && !(stop_in_freeze && freeze_mode);
  assign prescale_next = prescale_reg + 7'h01;

  // prescaler, each bit carry gives clk/2^n enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) prescale_reg <= 7'h00;
    else if (prescale_run) prescale_reg <= prescale_next;
  end

  // tap 0 is the raw bus rate, tap n is one pulse per 2^n cycles
  genvar t;
  assign tap[0] = prescale_run;
  generate
    for (t = 1; t < 8; t++) begin : g_tap
      assign tap[t] = prescale_run && (prescale_reg[t-1:0] == {t{1'b1}});
    end
  endgenerate
  assign clock_a = tap[prescale_a];
  assign clock_b = tap[prescale_b];

  // scaled sources from a and b
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scale_a_cnt_reg <= six_channel_pwm_pkg::scale_reset;
      scaled_clock_a_reg <= 1'b0;
    end else if (clock_a) begin
      // scale value 0 divides by 256
      if (scale_a_cnt_reg == 8'h01 || (scale_a_cnt_reg == 8'h00 && scale_a == 8'h01)) begin
        scale_a_cnt_reg <= scale_a;
        scaled_clock_a_reg <= !scaled_clock_a_reg;
      end else begin
        scale_a_cnt_reg <= scale_a_cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scale_b_cnt_reg <= six_channel_pwm_pkg::scale_reset;
      scaled_clock_b_reg <= 1'b0;
    end else if (clock_b) begin
      if (scale_b_cnt_reg == 8'h01 || (scale_b_cnt_reg == 8'h00 && scale_b == 8'h01)) begin
        scale_b_cnt_reg <= scale_b;
        scaled_clock_b_reg <= !scaled_clock_b_reg;
      end else begin
        scale_b_cnt_reg <= scale_b_cnt_reg - 8'h01;
      end
    end
  end

  // one enable per full scaled period: divider hit while output high
  assign scaled_clock_a = clock_a && scaled_clock_a_reg &&
    (scale_a_cnt_reg == 8'h01 || (scale_a_cnt_reg == 8'h00 && scale_a == 8'h01));
  assign scaled_clock_b = clock_b && scaled_clock_b_reg &&
    (scale_b_cnt_reg == 8'h01 || (scale_b_cnt_reg == 8'h00 && scale_b == 8'h01));

  // channels 0,1,4,5 use a/scaled a; 2,3 use b/scaled b
  genvar c;
  generate
    for (c = 0; c < nc; c++) begin : g_tick
      if (c == 2 || c == 3) begin : g_b
        assign tick[c] = chan_clock_scaled[c] ? scaled_clock_b : clock_b;
      end else begin : g_a
        assign tick[c] = chan_clock_scaled[c] ? scaled_clock_a : clock_a;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pin_sync_reg <= 2'b00;
    else pin_sync_reg <= {pin_sync_reg[0], pin5_in};
  end
  assign shut_event = shutdown_enable && (pin_sync_reg[1] == shutdown_level);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) shut_reg <= 1'b0;
    else if (!shutdown_enable) shut_reg <= 1'b0;
    else if (shut_event) shut_reg <= 1'b1;
    else if (shutdown_restart) shut_reg <= 1'b0;
  end

  // per-channel enable; channel 5 input while shutdown armed
  assign chan_on = chan_enable;

  // pairs: odd channel is the 16-bit channel, even idles
  genvar p;
  generate
    for (p = 0; p < six_channel_pwm_pkg::pair_count; p++) begin : g_pair
      wire [15:0] cnt_w;
      wire [7:0] lo_cnt;
      wire lo_wave;
      wire hi_wave;
      // idle upper byte zero
      // an unjoined channel never sees bits it does not own
      pwm_channel #(.width(16)) u_hi (
        .clk(clk),
        .resetn(resetn),
        .tick(concat_pair[p] ? tick[2*p] : tick[2*p+1]),
        .enable(concat_pair[p] ? chan_on[2*p+1] : chan_on[2*p+1]),
        .centre(concat_pair[p] ? chan_centre[2*p+1] : chan_centre[2*p+1]),
        .polarity(chan_polarity[2*p+1]),
        .period_buf(concat_pair[p] ?
          {period_set[16*p+7 -: 8], period_set[16*p+15 -: 8]} :
          {8'h00, period_set[16*p+15 -: 8]}),
        .duty_buf(concat_pair[p] ?
          {duty_set[16*p+7 -: 8], duty_set[16*p+15 -: 8]} :
          {8'h00, duty_set[16*p+15 -: 8]}),
        .count(cnt_w),
        .wave(hi_wave)
      );
      pwm_channel #(.width(cw)) u_lo (
        .clk(clk),
        .resetn(resetn),
        .tick(tick[2*p]),
        .enable(chan_on[2*p] && !concat_pair[p]),
        .centre(chan_centre[2*p]),
        .polarity(chan_polarity[2*p]),
        .period_buf(period_set[16*p+7 -: 8]),
        .duty_buf(duty_set[16*p+7 -: 8]),
        .count(lo_cnt),
        .wave(lo_wave)
      );
      assign chan_wave[2*p] = lo_wave;
      assign chan_wave[2*p+1] = hi_wave;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) count_state[16*p+15 -: 16] <= 16'h0000;
        else if (concat_pair[p]) count_state[16*p+15 -: 16] <= {cnt_w[7:0], cnt_w[15:8]};
        else count_state[16*p+15 -: 16] <= {cnt_w[7:0], lo_cnt};
      end
    end
  endgenerate

  // outputs: shutdown forces inactive level on channels 0-4 and 0 on channel 5; channel 5 pin is input when armed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_out <= 6'h00;
      pin5_oe <= 1'b0;
      shutdown_active <= 1'b0;
    end else begin
      pwm_out <= shut_reg ? (6'h00 | (~chan_polarity & 6'h1f & chan_on)) : chan_wave;
      pin5_oe <= chan_on[5] && !shutdown_enable;
      shutdown_active <= shut_reg;
    end
  end

  // counter restarts from zero on disable
  property p_disable_zero;
    @(posedge clk) disable iff (!resetn)
      (!chan_enable[1] && !concat_pair[0]) [*2] |=> count_state[15:8] == 8'h00 [*2];
  endproperty
  a_disable_zero: assert property (p_disable_zero) else $error("count not zero");

  // no prescaler advance in gated wait
  property p_wait_stop;
    @(posedge clk) disable iff (!resetn)
      stop_in_wait && wait_mode |=> $stable(prescale_reg);
  endproperty
  a_wait_stop: assert property (p_wait_stop) else $error("prescaler ran in wait");

  property p_freeze_stop;
    @(posedge clk) disable iff (!resetn)
      stop_in_freeze && freeze_mode |=> $stable(prescale_reg);
  endproperty
  a_freeze_stop: assert property (p_freeze_stop) else $error("prescaler ran in freeze");

  sequence s_pin_shut;
    shutdown_enable && pin5_in == shutdown_level ##1 shutdown_enable [*2];
  endsequence
  property p_shutdown;
    @(posedge clk) disable iff (!resetn)
      s_pin_shut |=> ##1 shutdown_active;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown missed");

  property p_off_low;
    @(posedge clk) disable iff (!resetn)
      !chan_enable[0] && !shut_reg |=> ##1 !pwm_out[0];
  endproperty
  a_off_low: assert property (p_off_low) else $error("disabled channel drives");

  property p_pin5_input;
    @(posedge clk) disable iff (!resetn)
      shutdown_enable |=> !pin5_oe;
  endproperty
  a_pin5_input: assert property (p_pin5_input) else $error("pin5 driven as input");

  property p_pin5_drive;
    @(posedge clk) disable iff (!resetn)
      chan_enable[5] && !shutdown_enable |=> pin5_oe;
  endproperty
  a_pin5_drive: assert property (p_pin5_drive) else $error("pin5 not driven");

  property p_shut_park;
    @(posedge clk) disable iff (!resetn)
      shutdown_active |-> pwm_out == (~$past(chan_polarity) & $past(chan_enable) & 6'h1f);
  endproperty
  a_shut_park: assert property (p_shut_park) else $error("shutdown output not parked");

  property p_shut_clear;
    @(posedge clk) disable iff (!resetn)
      !shutdown_enable |=> !shut_reg;
  endproperty
  a_shut_clear: assert property (p_shut_clear) else $error("shutdown latch stuck");

  sequence s_joined_quiet;
    concat_pair[0] ##1 !shut_reg;
  endsequence
  property p_even_idle;
    @(posedge clk) disable iff (!resetn)
      s_joined_quiet |=> !pwm_out[0];
  endproperty
  a_even_idle: assert property (p_even_idle) else $error("even half drives");

  property p_halt_ticks;
    @(posedge clk) disable iff (!resetn)
      !prescale_run |-> tick == 6'h00;
  endproperty
  a_halt_ticks: assert property (p_halt_ticks) else $error("tick while prescaler gated");
endmodule
`default_nettype wire

// [bench/six_channel_pwm_tb_top.sv]
// six_channel_pwm_tb_top: self-checking bench for the six-channel modulator
// assumes: design files compiled first; inputs driven on falling clk edges
`timescale 1ns/10ps
`default_nettype none
module six_channel_pwm_tb_top;
  logic clk = 1'b0; // 250 MHz clock
  logic resetn = 1'b0; // async reset, low active
  logic [5:0] chan_enable = 6'h00;
  logic [5:0] chan_polarity = 6'h3f;
  logic [5:0] chan_clock_scaled = 6'h00;
  logic [5:0] chan_centre = 6'h00;
  logic [2:0] prescale_a = 3'h0;
  logic [2:0] prescale_b = 3'h0;
  logic [7:0] scale_a = 8'h01;
  logic [7:0] scale_b = 8'h01;
  logic [2:0] concat_pair = 3'h0;
  logic stop_in_wait = 1'b0;
  logic stop_in_freeze = 1'b0;
  logic wait_mode = 1'b0;
  logic freeze_mode = 1'b0;
  logic shutdown_enable = 1'b0;
  logic shutdown_level = 1'b0;
  logic shutdown_restart = 1'b0;
  logic pin5_in = 1'b1; // pin idles high
  logic [47:0] period_set = {6{8'h04}};
  logic [47:0] duty_set = {6{8'h02}};
  logic [5:0] pwm_out;
  logic pin5_oe;
  logic shutdown_active;
  logic [47:0] count_state;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  // per, duty, centre, polarity, high cycles in 400
  int rt[7][5] = '{'{4,2,0,1,200}, '{4,1,0,1,100}, '{4,1,0,0,300}, '{4,0,0,1,0},
    '{4,4,0,1,400}, '{4,1,1,1,100}, '{5,2,1,1,160}};
  // ch, pre a, pre b, scale a, scale b, scaled, counter steps in 480
  int ct[6][7] = '{'{0,0,0,1,1,0,480}, '{0,2,0,1,1,0,120}, '{0,0,0,2,1,1,120},
    '{0,0,0,3,1,1,80}, '{2,0,1,1,1,0,240}, '{2,0,1,1,2,1,60}};
  // stop wait, stop freeze, wait, freeze, steps in 200
  int wt[5][5] = '{'{1,0,1,0,0}, '{0,0,1,0,200}, '{0,1,0,1,0}, '{0,0,0,1,200},
    '{1,0,0,1,200}};

  always #2 clk = ~clk;

  six_channel_pwm dut (.clk, .resetn, .chan_enable, .chan_polarity, .chan_clock_scaled,
    .chan_centre, .prescale_a, .prescale_b, .scale_a, .scale_b, .concat_pair,
    .stop_in_wait, .stop_in_freeze, .wait_mode, .freeze_mode, .shutdown_enable,
    .shutdown_level, .shutdown_restart, .period_set, .duty_set, .pin5_in, .pwm_out,
    .pin5_oe, .shutdown_active, .count_state);

  // one comparison, reported at once on mismatch
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // high cycles of one output; window is phase independent
  task automatic ones(input int ch, input int len, output int hi);
    hi = 0;
    repeat (len) begin
      @(negedge clk);
      if (pwm_out[ch] === 1'b1) hi++;
    end
  endtask

  // counter changes of one channel, one per tick
  task automatic steps(input int ch, input int len, output int st);
    logic [7:0] last;
    st = 0;
    last = count_state[8*ch +: 8];
    repeat (len) begin
      @(negedge clk);
      if (count_state[8*ch +: 8] !== last) st++;
      last = count_state[8*ch +: 8];
    end
  endtask

  // program while disabled so buffers load at once
  task automatic setup(input int ch, input int per, input int dty, input int ctr, input int pol);
    @(negedge clk);
    chan_enable[ch] = 1'b0;
    period_set[8*ch +: 8] = 8'(per);
    duty_set[8*ch +: 8] = 8'(dty);
    chan_centre[ch] = ctr[0];
    chan_polarity[ch] = pol[0];
    repeat (4) @(negedge clk);
    chan_enable[ch] = 1'b1;
    repeat (40) @(negedge clk);
  endtask

  // bounded wait for an 8-bit counter value
  task automatic wait_count(input int ch, input logic [7:0] v);
    int t;
    t = 0;
    while (count_state[8*ch +: 8] !== v && t < 1000) begin
      @(negedge clk);
      t++;
    end
    check(t < 1000, "counter value never seen");
  endtask

  // watchdog: tests need about 12k cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (3) @(negedge clk);
    check(pwm_out === 6'h00 && count_state === 48'h0 && pin5_oe === 1'b0, "reset state");
    resetn = 1'b1;
    for (int i = 0; i < 7; i++) begin
      setup(0, rt[i][0], rt[i][1], rt[i][2], rt[i][3]);
      ones(0, 400, n);
      check(n == rt[i][4], "duty ratio wrong");
    end
    $display("test ratio done");
    setup(0, 4, 2, 0, 1);
    setup(2, 4, 2, 0, 1);
    for (int i = 0; i < 6; i++) begin
      prescale_a = 3'(ct[i][1]);
      prescale_b = 3'(ct[i][2]);
      scale_a = 8'(ct[i][3]);
      scale_b = 8'(ct[i][4]);
      chan_clock_scaled = (ct[i][5] != 0) ? 6'h3f : 6'h00;
      repeat (40) @(negedge clk);
      steps(ct[i][0], 480, n);
      check(n == ct[i][6], "clock source rate wrong");
    end
    prescale_a = 3'h0;
    chan_clock_scaled = 6'h00;
    $display("test clocks done");
    for (int i = 0; i < 5; i++) begin
      stop_in_wait = wt[i][0][0];
      stop_in_freeze = wt[i][1][0];
      wait_mode = wt[i][2][0];
      freeze_mode = wt[i][3][0];
      repeat (10) @(negedge clk);
      steps(0, 200, n);
      check(n == wt[i][4], "low power gating wrong");
    end
    wait_mode = 1'b0;
    freeze_mode = 1'b0;
    $display("test low power done");
    setup(0, 100, 50, 0, 1);
    wait_count(0, 8'h0a);
    duty_set[7:0] = 8'h14;
    wait_count(0, 8'h23);
    check(pwm_out[0] === 1'b1, "duty took effect mid period");
    wait_count(0, 8'h00);
    wait_count(0, 8'h23);
    check(pwm_out[0] === 1'b0, "duty not loaded at period end");
    $display("test buffering done");
    chan_enable = 6'h00;
    concat_pair = 3'h1;
    period_set[15:0] = 16'h0001;
    duty_set[15:0] = 16'h4000;
    repeat (4) @(negedge clk);
    chan_enable = 6'h03;
    repeat (600) @(negedge clk);
    ones(1, 512, n);
    check(n == 128, "16-bit channel ratio wrong");
    concat_pair = 3'h0;
    chan_enable = 6'h00;
    @(negedge clk);
    period_set = {6{8'h08}};
    duty_set = 48'h060504030201;
    repeat (4) @(negedge clk);
    chan_enable = 6'h3f;
    repeat (20) @(negedge clk);
    chan_enable[2] = 1'b0;
    repeat (20) @(negedge clk);
    for (int c = 0; c < 6; c++) begin
      ones(c, 400, n);
      if (c == 2) begin
        check(n == 0 || n == 400, "disabled channel toggles");
      end else begin
        check(n == (c + 1) * 50, "channel ratio wrong");
      end
    end
    check(pin5_oe === 1'b1, "pin 5 not driven");
    $display("test six channels done");
    shutdown_enable = 1'b1;
    repeat (10) @(negedge clk);
    check(pin5_oe === 1'b0 && shutdown_active === 1'b0, "pin 5 not input");
    pin5_in = 1'b0;
    repeat (10) @(negedge clk);
    check(shutdown_active === 1'b1, "shutdown not latched");
    ones(0, 200, n);
    check(n == 0, "output active in shutdown");
    pin5_in = 1'b1;
    shutdown_restart = 1'b1;
    n = 0;
    while (shutdown_active !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(n < 1000, "shutdown never released");
    $display("test shutdown done");
    resetn = 1'b0;
    #1;
    check(pwm_out === 6'h00 && count_state === 48'h0, "outputs not cleared in reset");
    give_verdict();
  end
endmodule
`default_nettype wire
